// ==== logic/ditm_top.sv ====
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ditm_top (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic [6:0] TERMINAL_N,
  input wire logic [15:0] ANALOG_INPUT_1,
  input wire logic [15:0] ANALOG_INPUT_2,
  output ditm_pkg::ditm_cmd_t CMD,
  output logic signed [15:0] AI1_SETTING,
  output logic signed [15:0] AI2_SETTING,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  logic [7:0] ctrl_q;
  logic [15:0] prot_hi_q;
  logic [15:0] prot_lo_q;
  logic [6:0] sel_q [ditm_pkg::N_TERM];
  logic [1:0][3:0][15:0] pin_q;
  logic [1:0][3:0][15:0] pset_q;
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  ditm_pkg::ditm_cmd_t cmd_q;
  ditm_pkg::ditm_cmd_t cmd_d;
  logic signed [15:0] ai1_q;
  logic signed [15:0] ai2_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  function automatic logic [2:0] region(input logic [7:0] a);
    logic [2:0] r;
    r = ditm_pkg::RG_NONE;
    if (a[1:0] != 2'h0) r = ditm_pkg::RG_NONE;
    else if (a == ditm_pkg::OFF_CTRL) r = ditm_pkg::RG_CTRL;
    else if (a == ditm_pkg::OFF_STAT) r = ditm_pkg::RG_STAT;
    else if (a == ditm_pkg::OFF_PROT) r = ditm_pkg::RG_PROT;
    else if (a[7:5] == ditm_pkg::OFF_FUNC[7:5] && a[4:2] != 3'h7) r = ditm_pkg::RG_FUNC;
    else if (a[7:6] == ditm_pkg::OFF_CURVE[7:6]) begin
      r = a[2] ? ditm_pkg::RG_CSET : ditm_pkg::RG_CIN;
    end
    return r;
  endfunction

  // curve word: bit 5 picks the curve, bits 4:3 the point, bit 2 input or setting
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (region(a))
      ditm_pkg::RG_CTRL: v = {24'h00_0000, ctrl_q};
      ditm_pkg::RG_STAT: v = {15'h0000, cmd_q};
      ditm_pkg::RG_PROT: v = {prot_hi_q, prot_lo_q};
      ditm_pkg::RG_FUNC: v = {25'h000_0000, sel_q[a[4:2]]};
      ditm_pkg::RG_CIN: v = {16'h0000, pin_q[a[5]][a[4:3]]};
      ditm_pkg::RG_CSET: v = {{16{pset_q[a[5]][a[4:3]][15]}}, pset_q[a[5]][a[4:3]]};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic signed [15:0] interp(input logic [15:0] x,
      input logic [3:0][15:0] xs, input logic [3:0][15:0] ys, input logic knees);
    int xi;
    int x0;
    int x1;
    int y0;
    int y1;
    int r;
    xi = int'(x);
    x0 = int'(xs[0]);
    x1 = int'(xs[3]);
    y0 = int'($signed(ys[0]));
    y1 = int'($signed(ys[3]));
    if (knees && x >= xs[2]) begin
      x0 = int'(xs[2]);
      y0 = int'($signed(ys[2]));
    end else if (knees && x >= xs[1]) begin
      x0 = int'(xs[1]);
      x1 = int'(xs[2]);
      y0 = int'($signed(ys[1]));
      y1 = int'($signed(ys[2]));
    end else if (knees) begin
      x1 = int'(xs[1]);
      y1 = int'($signed(ys[1]));
    end
    if (x <= xs[0]) r = int'($signed(ys[0]));
    else if (x >= xs[3]) r = int'($signed(ys[3]));
    else if (x1 <= x0) r = y0;
    else r = y0 + ((xi - x0) * (y1 - y0)) / (x1 - x0);
    return r[15:0];
  endfunction

  // terminals act when pulled to the common return, i.e. pin reads low
  wire [6:0] term_act = ~sync2_q;
  function automatic logic hit(input logic [6:0] code, input logic want_open);
    logic h;
    h = 1'b0;
    for (int t = 0; t < ditm_pkg::N_TERM; t++) begin
      h = h | ((term_act[t] ^ want_open) & (sel_q[t] == code));
    end
    return h;
  endfunction

  wire aw_hs = S_AXI_AWVALID & awready_q;
  wire w_hs = S_AXI_WVALID & wready_q;
  wire b_hs = bvalid_q & S_AXI_BREADY;
  wire ar_hs = S_AXI_ARVALID & arready_q;
  wire r_hs = rvalid_q & S_AXI_RREADY;
  wire do_write = ~awready_q & ~wready_q & ~bvalid_q;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  // rd_word reads register state: a continuous assign would miss its updates
  logic [31:0] wv;
  always_comb begin
    wv = (rd_word(awaddr_q) & ~wmask) | (wdata_q & wmask);
  end
  wire [2:0] wr_rg = region(awaddr_q);
  wire wr_c = awaddr_q[5];
  wire [1:0] wr_p = awaddr_q[4:3];
  wire [15:0] in_lo = (wr_p == 2'h0) ? 16'h0000 : pin_q[wr_c][wr_p - 2'h1];
  wire [15:0] in_hi = (wr_p == 2'h3) ? ditm_pkg::V_MAX : pin_q[wr_c][wr_p + 2'h1];
  wire in_ok = wv[31:16] == 16'h0000 && wv[15:0] >= in_lo && wv[15:0] <= in_hi;
  wire set_ok = $signed(wv) >= -ditm_pkg::SET_LIMIT && $signed(wv) <= ditm_pkg::SET_LIMIT;
  wire prot_ok = wv[31:16] >= wv[15:0] && wv[31:16] <= ditm_pkg::V_MAX;
  wire func_ok = wv[31:7] == 25'h000_0000 && wv[6:0] <= ditm_pkg::FN_MAX;
  wire wr_ok = (wr_rg == ditm_pkg::RG_CTRL)
      || (wr_rg == ditm_pkg::RG_PROT && prot_ok)
      || (wr_rg == ditm_pkg::RG_FUNC && func_ok)
      || (wr_rg == ditm_pkg::RG_CIN && in_ok)
      || (wr_rg == ditm_pkg::RG_CSET && set_ok);
  wire wr_go = do_write & wr_ok;
  wire reload = wr_go && wr_rg == ditm_pkg::RG_CTRL && wv[ditm_pkg::CTRL_RELOAD];
  wire [1:0] mode = ctrl_q[ditm_pkg::CTRL_MODE_LSB +: 2];
  wire alt_mode = mode[1];
  wire term_src = ctrl_q[ditm_pkg::CTRL_SRC_LSB +: 2] == ditm_pkg::RUN_SRC_TERM;
  wire updn_src = ctrl_q[ditm_pkg::CTRL_UPDN];

  // bus slave: one write and one read in flight, write answered after both beats
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= ditm_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (CE) begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? ditm_pkg::RESP_OKAY : ditm_pkg::RESP_SLVERR;
      end
      if (b_hs) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= ditm_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (CE) begin
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word(S_AXI_ARADDR);
        rresp_q <= (region(S_AXI_ARADDR) == ditm_pkg::RG_NONE) ?
            ditm_pkg::RESP_SLVERR : ditm_pkg::RESP_OKAY;
      end else if (r_hs) begin
        arready_q <= 1'b1;
        rvalid_q <= 1'b0;
      end
    end
  end

  // reload bit is a command, not stored: it reads back as zero
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ctrl_q <= ditm_pkg::CTRL_RST;
      prot_hi_q <= ditm_pkg::PROT_HI_RST;
      prot_lo_q <= ditm_pkg::PROT_LO_RST;
    end else if (CE && wr_go) begin
      if (wr_rg == ditm_pkg::RG_CTRL) ctrl_q <= wv[7:0];
      if (wr_rg == ditm_pkg::RG_PROT) begin
        prot_hi_q <= wv[31:16];
        prot_lo_q <= wv[15:0];
      end
    end
  end

  // defaults follow the mode only when software asks for a reload
  for (genvar t = 0; t < ditm_pkg::N_TERM; t++) begin : g_sel
    always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
        sel_q[t] <= ditm_pkg::FUNC_RST[t];
      end else if (CE && reload) begin
        if (t == 1 && ctrl_q[ditm_pkg::CTRL_AUX]) sel_q[t] <= ditm_pkg::FN_AUX_ALT;
        else if (alt_mode) sel_q[t] <= ditm_pkg::FUNC_ALT[t];
        else sel_q[t] <= ditm_pkg::FUNC_RST[t];
      end else if (CE && wr_go && wr_rg == ditm_pkg::RG_FUNC && awaddr_q[4:2] == t) begin
        sel_q[t] <= wv[6:0];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      for (int c = 0; c < 2; c++) begin
        pin_q[c] <= ditm_pkg::CURVE_IN_RST;
        pset_q[c] <= ditm_pkg::CURVE_SET_RST;
      end
    end else if (CE && wr_go) begin
      if (wr_rg == ditm_pkg::RG_CIN) pin_q[wr_c][wr_p] <= wv[15:0];
      if (wr_rg == ditm_pkg::RG_CSET) pset_q[wr_c][wr_p] <= wv[15:0];
    end
  end

  // terminal pins are asynchronous contacts: two stages before any use
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sync1_q <= 7'h7F;
      sync2_q <= 7'h7F;
    end else if (CE) begin
      sync1_q <= TERMINAL_N;
      sync2_q <= sync1_q;
    end
  end

  always_comb begin
    cmd_d = '0;
    cmd_d.forward_run_cmd = term_src & hit(ditm_pkg::FN_FWD, 1'b0);
    cmd_d.reverse_run_cmd = term_src & hit(ditm_pkg::FN_REV, 1'b0);
    cmd_d.jog_fwd = term_src & hit(ditm_pkg::FN_JOG_F, 1'b0);
    cmd_d.jog_rev = term_src & hit(ditm_pkg::FN_JOG_R, 1'b0);
    cmd_d.coast = hit(ditm_pkg::FN_COAST, 1'b0);
    cmd_d.fault_reset = hit(ditm_pkg::FN_FLT_RST, 1'b0);
    cmd_d.ext_fault = hit(ditm_pkg::FN_EXT_NO, 1'b0)
        | hit(ditm_pkg::FN_EXT_NC, 1'b1);
    cmd_d.estop = hit(ditm_pkg::FN_ESTOP, 1'b0);
    cmd_d.freq_up = updn_src & hit(ditm_pkg::FN_UP, 1'b0);
    cmd_d.freq_down = updn_src & hit(ditm_pkg::FN_DOWN, 1'b0);
    cmd_d.updn_clear = hit(ditm_pkg::FN_UPDN_CLR, 1'b0);
    for (int k = 0; k < 4; k++) begin
      cmd_d.segment[k] = hit(ditm_pkg::FN_MS1 + 7'(k), 1'b0);
    end
    cmd_d.overrun = ANALOG_INPUT_1 > prot_hi_q || ANALOG_INPUT_1 < prot_lo_q;
    // a fault seen in the same cycle as a reset still latches
    cmd_d.fault_state = cmd_q.ext_fault | (cmd_q.fault_state & ~cmd_q.fault_reset);
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cmd_q <= '0;
      ai1_q <= 16'sh0000;
      ai2_q <= 16'sh0000;
    end else if (CE) begin
      cmd_q <= cmd_d;
      ai1_q <= interp(ANALOG_INPUT_1, pin_q[0], pset_q[0], ctrl_q[ditm_pkg::CTRL_AI1_EN]);
      ai2_q <= interp(ANALOG_INPUT_2, pin_q[1], pset_q[1], ctrl_q[ditm_pkg::CTRL_AI2_EN]);
    end
  end

  assign CMD = cmd_q;
  assign AI1_SETTING = ai1_q;
  assign AI2_SETTING = ai2_q;
  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // separate decode of the four speed lines, for the index check
  logic [3:0] seg_lines;
  always_comb begin
    seg_lines = 4'h0;
    for (int t = 0; t < ditm_pkg::N_TERM; t++) begin
      if (term_act[t] && sel_q[t] >= ditm_pkg::FN_MS1
          && sel_q[t] <= ditm_pkg::FN_MS1 + 7'h3) begin
        seg_lines[2'(sel_q[t] - ditm_pkg::FN_MS1)] = 1'b1;
      end
    end
  end

  sequence s_ext_fault;
    CE && cmd_q.ext_fault;
  endsequence
  sequence s_clean_reset;
    CE && cmd_q.fault_reset && !cmd_q.ext_fault;
  endsequence

  curve_order_a: assert property (pin_q[0][0] <= pin_q[0][1] && pin_q[0][1] <= pin_q[0][2]
      && pin_q[0][2] <= pin_q[0][3] && pin_q[0][3] <= ditm_pkg::V_MAX)
    else $error("curve one input points out of order");
  set_range_a: assert property ($signed(pset_q[0][1]) <= 16'sd2000
      && $signed(pset_q[0][1]) >= -16'sd2000)
    else $error("curve setting beyond two hundred percent");
  reset_dflt_a: assert property (disable iff (1'b0) $past(SYS_RST) |->
      pin_q[0][1] == 16'h012C && pin_q[0][2] == 16'h0258 && pin_q[0][3] == 16'h03E8)
    else $error("curve one knees not at reset values");
  ai2_dflt_a: assert property (disable iff (1'b0) $past(SYS_RST) |->
      pset_q[1][1] == 16'h012C && pset_q[1][2] == 16'h0258 && pset_q[1][3] == 16'h03E8)
    else $error("curve two settings not at reset values");
  prot_order_a: assert property (prot_hi_q >= prot_lo_q)
    else $error("protection window inverted");
  pulse_dflt_a: assert property (disable iff (1'b0) $past(SYS_RST) |->
      sel_q[6] == 7'h2D ##1 sel_q[6] <= ditm_pkg::FN_MAX)
    else $error("pulse terminal selector wrong after reset");
  mode_reload_a: assert property (CE && reload && mode[1] && !ctrl_q[ditm_pkg::CTRL_AUX]
      |=> sel_q[0] == 7'h3A && sel_q[5] == 7'h3F)
    else $error("alternate defaults not applied");
  aux_reload_a: assert property (CE && reload && ctrl_q[ditm_pkg::CTRL_AUX]
      |=> sel_q[1] == 7'h3B)
    else $error("auxiliary default not applied");
  run_gate_a: assert property (CE && !term_src |=> !cmd_q.forward_run_cmd
      && !cmd_q.reverse_run_cmd && !cmd_q.jog_fwd && !cmd_q.jog_rev)
    else $error("run command outside terminal source");
  ext_fault_a: assert property (s_ext_fault |=> cmd_q.fault_state)
    else $error("external fault did not latch");
  fault_clear_a: assert property (s_clean_reset |=> !cmd_q.fault_state)
    else $error("fault reset ignored");
  seg_index_a: assert property (CE |=> cmd_q.segment == $past(seg_lines))
    else $error("segment index mismatch");
  overrun_a: assert property (CE && (ANALOG_INPUT_1 > prot_hi_q) |=> cmd_q.overrun)
    else $error("overrun flag missing");
endmodule

// ==== logic/ditm_pkg.sv ====
package ditm_pkg;
  // units: voltages in 0.01 V steps, settings in 0.1 % steps (signed)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_PROT = 8'h08;
  localparam logic [7:0] OFF_FUNC = 8'h40;
  localparam logic [7:0] OFF_CURVE = 8'h80;
  localparam int CTRL_AI1_EN = 0;
  localparam int CTRL_AI2_EN = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_AUX = 4;
  localparam int CTRL_SRC_LSB = 5;
  localparam int CTRL_UPDN = 7;
  localparam int CTRL_RELOAD = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] RUN_SRC_TERM = 2'h1;
  localparam logic [15:0] V_MAX = 16'h03E8;
  localparam logic [3:0][15:0] CURVE_IN_RST = {16'h03E8, 16'h0258, 16'h012C, 16'h0000};
  localparam logic [3:0][15:0] CURVE_SET_RST = {16'h03E8, 16'h0258, 16'h012C, 16'h0000};
  localparam int SET_LIMIT = 2000;
  localparam logic [15:0] PROT_HI_RST = 16'h02A8;
  localparam logic [15:0] PROT_LO_RST = 16'h0136;
  localparam int N_TERM = 7;
  localparam logic [6:0] FN_MAX = 7'h41;
  localparam logic [6:0] FN_FWD = 7'h01;
  localparam logic [6:0] FN_REV = 7'h02;
  localparam logic [6:0] FN_JOG_F = 7'h04;
  localparam logic [6:0] FN_JOG_R = 7'h05;
  localparam logic [6:0] FN_COAST = 7'h06;
  localparam logic [6:0] FN_FLT_RST = 7'h07;
  localparam logic [6:0] FN_EXT_NO = 7'h08;
  localparam logic [6:0] FN_EXT_NC = 7'h09;
  localparam logic [6:0] FN_ESTOP = 7'h0A;
  localparam logic [6:0] FN_UP = 7'h0C;
  localparam logic [6:0] FN_DOWN = 7'h0D;
  localparam logic [6:0] FN_UPDN_CLR = 7'h0E;
  localparam logic [6:0] FN_MS1 = 7'h0F;
  localparam logic [6:0] FN_AUX_ALT = 7'h3B;
  // terminal 0..5 = digital terminals 1..6, terminal 6 = fast pulse terminal
  localparam logic [6:0][6:0] FUNC_RST = {7'h2D, 7'h00, 7'h08, 7'h07, 7'h04, 7'h02, 7'h01};
  localparam logic [6:0][6:0] FUNC_ALT = {7'h2D, 7'h3F, 7'h3E, 7'h3D, 7'h3C, 7'h02, 7'h3A};
  localparam logic [2:0] RG_NONE = 3'h0;
  localparam logic [2:0] RG_CTRL = 3'h1;
  localparam logic [2:0] RG_STAT = 3'h2;
  localparam logic [2:0] RG_PROT = 3'h3;
  localparam logic [2:0] RG_FUNC = 3'h4;
  localparam logic [2:0] RG_CIN = 3'h5;
  localparam logic [2:0] RG_CSET = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic fault_state;
    logic overrun;
    logic [3:0] segment;
    logic updn_clear;
    logic freq_down;
    logic freq_up;
    logic estop;
    logic ext_fault;
    logic fault_reset;
    logic coast;
    logic jog_rev;
    logic jog_fwd;
    logic reverse_run_cmd;
    logic forward_run_cmd;
  } ditm_cmd_t;
endpackage

// ==== test/ditm_contacts.sv ====
`timescale 1ns/1ps
module ditm_contacts (
  input wire logic [6:0] closed,
  input wire logic [15:0] volts_1,
  input wire logic [15:0] volts_2,
  output logic [6:0] terminal_n,
  output logic [15:0] analog_1,
  output logic [15:0] analog_2
);
  // a closed contact pulls its pin to common, an open one leaves the pull-up high
  assign terminal_n = ~closed;
  // sources are ideal and settle within the cycle they change
  assign analog_1 = volts_1;
  assign analog_2 = volts_2;
endmodule

// ==== test/drive_input_terminal_mapper_bench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module drive_input_terminal_mapper_bench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [6:0] closed = 7'h00;
  logic [15:0] v1 = 16'h01F4;
  logic [15:0] v2 = 16'h0000;
  wire logic [6:0] term_n;
  wire logic [15:0] a1;
  wire logic [15:0] a2;
  ditm_pkg::ditm_cmd_t cmd;
  logic signed [15:0] s1;
  logic signed [15:0] s2;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready;
  logic wready;
  logic bvalid;
  logic arready;
  logic rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  int failures = 0;
  int total_checks = 0;
  int cx[2][4] = '{'{0, 300, 600, 1000}, '{0, 300, 600, 1000}};
  int cy[2][4] = '{'{0, 300, 600, 1000}, '{0, 300, 600, 1000}};
  int fn_tab[3][7] = '{'{1, 2, 4, 7, 8, 0, 45}, '{58, 59, 60, 61, 62, 63, 45},
    '{58, 2, 60, 61, 62, 63, 45}};
  logic [31:0] rl_ctrl[3] = '{32'h00000100, 32'h00000118, 32'h0000010C};
  logic [6:0] codes[10] = '{7'h01, 7'h02, 7'h04, 7'h05, 7'h06, 7'h07, 7'h0A, 7'h0C, 7'h0D, 7'h0E};
  int corner[6] = '{309, 310, 680, 681, 300, 1100};

  always #5 mclk = ~mclk;

  ditm_contacts contacts (
    .closed(closed),
    .volts_1(v1),
    .volts_2(v2),
    .terminal_n(term_n),
    .analog_1(a1),
    .analog_2(a2)
  );

  ditm_top uut (
    .MCLK(mclk),
    .SYS_RST(sys_rst),
    .CE(ce),
    .TERMINAL_N(term_n),
    .ANALOG_INPUT_1(a1),
    .ANALOG_INPUT_2(a2),
    .CMD(cmd),
    .AI1_SETTING(s1),
    .AI2_SETTING(s2),
    .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready)
  );

  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // each bus task starts one edge later so no signal is assigned twice in a time step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aw;
    bit w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 100) begin
      @(posedge mclk);
      n++;
      if (!aw && !w && bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    failures++;
    end_of_test();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100) begin
      @(posedge mclk);
      n++;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    failures++;
    end_of_test();
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, d, r);
    `CHK("bresp", er, r)
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK("rresp", er, r)
    `CHK("rdata", ed, d)
  endtask

  function automatic ditm_pkg::ditm_cmd_t exp_cmd(input logic [6:0] fn, input logic [31:0] ctrl);
    ditm_pkg::ditm_cmd_t c;
    logic run_ok;
    c = '0;
    run_ok = ctrl[6:5] == 2'h1;
    case (fn)
      7'h01: c.forward_run_cmd = run_ok;
      7'h02: c.reverse_run_cmd = run_ok;
      7'h04: c.jog_fwd = run_ok;
      7'h05: c.jog_rev = run_ok;
      7'h06: c.coast = 1'b1;
      7'h07: c.fault_reset = 1'b1;
      7'h0A: c.estop = 1'b1;
      7'h0C: c.freq_up = ctrl[7];
      7'h0D: c.freq_down = ctrl[7];
      7'h0E: c.updn_clear = 1'b1;
      default: c = '0;
    endcase
    return c;
  endfunction

  function automatic logic signed [15:0] interp(input int c, input int x, input bit knees);
    int a;
    int b;
    if (x <= cx[c][0]) return cy[c][0][15:0];
    if (x >= cx[c][3]) return cy[c][3][15:0];
    a = 0;
    b = 3;
    if (knees) begin
      while (x >= cx[c][a + 1]) a++;
      b = a + 1;
    end
    return 16'(cy[c][a] + (cy[c][b] - cy[c][a]) * (x - cx[c][a]) / (cx[c][b] - cx[c][a]));
  endfunction

  task automatic term_try(input logic [6:0] fn, input logic [31:0] ctrl);
    ditm_pkg::ditm_cmd_t e;
    e = exp_cmd(fn, ctrl);
    wr_chk(8'h40, {25'h0, fn}, 2'h0);
    closed <= 7'h01;
    wait_n(4);
    `CHK("cmd", e, cmd)
    closed <= 7'h00;
    wait_n(4);
  endtask

  initial begin
    int x;
    void'($urandom(60487));
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      for (int p = 0; p < 4; p++) begin
        rd_chk(8'(128 + 32 * c + 8 * p), cx[c][p], 2'h0);
        rd_chk(8'(132 + 32 * c + 8 * p), cy[c][p], 2'h0);
      end
    end
    rd_chk(8'h08, 32'h02A80136, 2'h0);
    for (int t = 0; t < 7; t++) rd_chk(8'(64 + 4 * t), fn_tab[0][t], 2'h0);
    wr_chk(8'h40, 32'h00000042, 2'h2);
    wr_chk(8'h40, 32'h00000041, 2'h0);
    wr_chk(8'h08, 32'h01000200, 2'h2);
    wr_chk(8'h08, 32'h02000200, 2'h0);
    wr_chk(8'h08, 32'h02A80136, 2'h0);
    wr_chk(8'h98, 32'h000003E9, 2'h2);
    wr_chk(8'h88, 32'h00000259, 2'h2);
    wr_chk(8'h84, 32'h000007D1, 2'h2);
    wr_chk(8'h84, 32'hFFFFF82F, 2'h2);
    wr_chk(8'h84, 32'hFFFFF830, 2'h0);
    wr_chk(8'hAC, 32'hFFFFFD44, 2'h0);
    wr_chk(8'h04, 32'h00000000, 2'h2);
    wr_chk(8'h3C, 32'h00000000, 2'h2);
    rd_chk(8'h84, 32'hFFFFF830, 2'h0);
    rd_chk(8'h3C, 32'h00000000, 2'h2);
    cy[0][0] = -2000;
    cy[1][1] = -700;
    // second pass enables the terminal run source and the up/down source
    for (int j = 0; j < 2; j++) begin
      wr_chk(8'h00, j ? 32'h000000A0 : 32'h00000000, 2'h0);
      for (int i = 0; i < 10; i++) begin
        term_try(codes[i], j ? 32'h000000A0 : 32'h00000000);
      end
    end
    wr_chk(8'h40, 32'h00000008, 2'h0);
    wr_chk(8'h44, 32'h00000007, 2'h0);
    closed <= 7'h01;
    wait_n(5);
    `CHK("ext_fault", 1'b1, cmd.ext_fault)
    `CHK("fault_state", 1'b1, cmd.fault_state)
    closed <= 7'h00;
    wait_n(5);
    `CHK("fault_held", 1'b1, cmd.fault_state)
    closed <= 7'h02;
    wait_n(5);
    `CHK("fault_cleared", 1'b0, cmd.fault_state)
    closed <= 7'h00;
    wr_chk(8'h40, 32'h00000009, 2'h0);
    wait_n(5);
    `CHK("nc_open", 1'b1, cmd.ext_fault)
    closed <= 7'h01;
    wait_n(5);
    `CHK("nc_closed", 1'b0, cmd.ext_fault)
    rd_chk(8'h04, 32'h00010000, 2'h0);
    for (int t = 0; t < 4; t++) wr_chk(8'(64 + 4 * t), 32'(15 + t), 2'h0);
    for (int i = 0; i < 10; i++) begin
      x = i == 0 ? 15 : (i == 1 ? 0 : $urandom_range(15));
      closed <= 7'(x);
      wait_n(4);
      `CHK("segment", 4'(x), cmd.segment)
    end
    // clock enable low must freeze the pin path and the command outputs
    ce <= 1'b0;
    closed <= 7'h05;
    wait_n(6);
    `CHK("ce_hold", 4'(x), cmd.segment)
    ce <= 1'b1;
    wait_n(4);
    `CHK("ce_run", 4'h5, cmd.segment)
    closed <= 7'h00;
    for (int j = 0; j < 2; j++) begin
      wr_chk(8'h00, j ? 32'h000000A3 : 32'h000000A0, 2'h0);
      for (int i = 0; i < 16; i++) begin
        x = i < 6 ? corner[i] : $urandom_range(1100);
        v1 <= 16'(x);
        v2 <= 16'(1100 - x);
        wait_n(3);
        `CHK("ai1", interp(0, x, j), s1)
        `CHK("ai2", interp(1, 1100 - x, j), s2)
        `CHK("overrun", x > 680 || x < 310, cmd.overrun)
      end
    end
    for (int k = 0; k < 3; k++) begin
      // the reload strobe uses the stored mode and aux bits, so store them first
      wr_chk(8'h00, rl_ctrl[k] & 32'h0000_00FF, 2'h0);
      wr_chk(8'h00, rl_ctrl[k], 2'h0);
      for (int t = 0; t < 7; t++) rd_chk(8'(64 + 4 * t), fn_tab[k][t], 2'h0);
    end
    end_of_test();
  end
endmodule
